// ---- rtl/lco_cmd.sv ----
`timescale 1ns/10ps
// Operation
// - shape bit: 0 underline, 1 block
// - direction from command low two bits
// - horizontal one byte, vertical by pitch
// - step applied after every memory access
// - composition field picks OR/XOR/AND/priority
// - one composition method for both blocks
// - priority-OR equals OR without flashing
// - text first layer disables third layer
// - two bits select blocks one, three mode
// - blocks two and four always graphics
// - layer-count bit selects two or three
// - whole display pixel shift zero to seven
// - sixteen-bit cursor address drives memory
// - address changes only by set or step
// - read address returns low then high
// - stream writes advance address each byte
// - memory read streams, advancing per read
module lco_cmd
    import lco_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cmd_sel_i,             // 1 = command byte, 0 = data byte
    input wire logic [7:0] wdata_i,         // host write byte
    input wire logic wr_i,                  // write strobe
    input wire logic rd_i,                  // read strobe
    output logic [7:0] rdata_o,             // read data, one cycle later
    output logic cursor_block_o,            // block cursor shape
    output logic [1:0] compose_sel_o,       // layer composition method
    output logic block1_graphics_o,         // block one graphics
    output logic block2_graphics_o,         // block two graphics
    output logic block3_graphics_o,         // block three graphics
    output logic block4_graphics_o,         // block four graphics
    output logic third_layer_en_o,          // third layer shown
    output logic flash_priority_o,          // priority rules under flashing
    output logic [2:0] hscroll_o,           // whole-display pixel shift
    output logic [15:0] cursor_addr_o       // cursor / memory address
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        LCO_ST_IDLE  = 6'b000001,           // no command open
        LCO_ST_PARAM = 6'b000010,           // collecting parameters
        LCO_ST_MWR   = 6'b000100,           // memory write stream
        LCO_ST_MRD   = 6'b001000,           // memory read stream
        LCO_ST_RADDR = 6'b010000,           // address read-back
        LCO_ST_SKIP  = 6'b100000            // unknown command, data ignored
    } lco_state_e;

    lco_state_e st_q, st_d;                 // interpreter state
    logic [7:0] cmd_q, cmd_d;               // open command code
    logic [3:0] pidx_q, pidx_d;             // parameter index
    logic [15:0] addr_q, addr_d;            // cursor address register
    logic [1:0] dir_q, dir_d;               // step direction
    logic [15:0] pitch_q, pitch_d;          // address pitch in bytes
    logic shape_q, shape_d;                 // cursor_shape_bit
    logic [4:0] ovl_q, ovl_d;               // overlay parameter bits
    logic [2:0] hsc_q, hsc_d;               // pixel scroll amount
    logic hi_q, hi_d;                       // next address read is high byte
    logic [7:0] rdata_q, rdata_d;           // read data register
    logic first_q, first_d;                 // first read of a memory stream
    lco_mem_if mif();                       // memory port

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // address after one step in the chosen direction
    function automatic logic [15:0] step_addr(input logic [15:0] a, input logic [1:0] d,
                                              input logic [15:0] p);
        case (d)
            LCO_DIR_RIGHT: step_addr = a + 16'h0001;
            LCO_DIR_LEFT:  step_addr = a - 16'h0001;
            LCO_DIR_UP:    step_addr = a - p;
            default:       step_addr = a + p;
        endcase
    endfunction

    // memory instance
    lco_vram u_vram (
        .clk_i(clk_i),
        .m(mif.mem)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        cmd_d = cmd_q;
        pidx_d = pidx_q;
        addr_d = addr_q;
        dir_d = dir_q;
        pitch_d = pitch_q;
        shape_d = shape_q;
        ovl_d = ovl_q;
        hsc_d = hsc_q;
        hi_d = hi_q;
        first_d = first_q;
        rdata_d = 8'h00;
        mif.we = 1'b0;
        mif.wdata = wdata_i;
        mif.addr = addr_q;
        if (wr_i && cmd_sel_i) begin
            // a new command closes whatever was open
            cmd_d = wdata_i;
            pidx_d = 4'h0;
            hi_d = 1'b0;
            first_d = 1'b1;
            case (wdata_i)
                CMD_MEM_WRITE: st_d = LCO_ST_MWR;
                CMD_MEM_READ:  st_d = LCO_ST_MRD;
                CMD_READ_ADDR: st_d = LCO_ST_RADDR;
                CMD_SET_ADDR, CMD_OVERLAY, CMD_HSCROLL, CMD_CSR_FORM, CMD_PITCH: begin
                    st_d = LCO_ST_PARAM;
                end
                default: begin
                    if (wdata_i[7:2] == CMD_DIR_BASE[7:2]) begin
                        dir_d = wdata_i[1:0];
                        st_d = LCO_ST_IDLE;
                    end else begin
                        st_d = LCO_ST_SKIP;
                    end
                end
            endcase
        end else if (wr_i) begin
            case (st_q)
                LCO_ST_PARAM: begin
                    pidx_d = pidx_q + 4'h1;
                    case (cmd_q)
                        CMD_SET_ADDR: begin
                            if (pidx_q == 4'h0) begin
                                addr_d[7:0] = wdata_i;
                            end else if (pidx_q == 4'h1) begin
                                addr_d[15:8] = wdata_i;
                            end
                        end
                        CMD_OVERLAY: begin
                            if (pidx_q == 4'h0) begin
                                ovl_d = wdata_i[4:0];
                            end
                        end
                        CMD_HSCROLL: begin
                            if (pidx_q == 4'h0) begin
                                hsc_d = wdata_i[2:0];
                            end
                        end
                        CMD_CSR_FORM: begin
                            if (pidx_q == 4'h1) begin
                                shape_d = wdata_i[SHAPE_BIT];
                            end
                        end
                        CMD_PITCH: begin
                            if (pidx_q == 4'(PITCH_P_LO)) begin
                                pitch_d[7:0] = wdata_i;
                            end else if (pidx_q == 4'(PITCH_P_LO + 1)) begin
                                pitch_d[15:8] = wdata_i;
                            end
                        end
                        default: begin
                        end
                    endcase
                end
                LCO_ST_MWR: begin
                    mif.we = 1'b1;
                    addr_d = step_addr(addr_q, dir_q, pitch_q);
                end
                default: begin
                end
            endcase
        end else if (rd_i) begin
            case (st_q)
                LCO_ST_RADDR: begin
                    rdata_d = hi_q ? addr_q[15:8] : addr_q[7:0];
                    hi_d = ~hi_q;
                end
                LCO_ST_MRD: begin
                    // memory output holds the byte at the current address
                    rdata_d = mif.rdata;
                    addr_d = step_addr(addr_q, dir_q, pitch_q);
                    mif.addr = addr_d;              // fetch the next byte
                    first_d = 1'b0;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st_q <= LCO_ST_IDLE;
            cmd_q <= 8'h00;
            pidx_q <= 4'h0;
            addr_q <= ADDR_RST;
            dir_q <= LCO_DIR_RIGHT;
            pitch_q <= PITCH_RST;
            shape_q <= 1'b0;
            ovl_q <= 5'h00;
            hsc_q <= 3'h0;
            hi_q <= 1'b0;
            first_q <= 1'b1;
            rdata_q <= 8'h00;
        end else begin
            st_q <= st_d;
            cmd_q <= cmd_d;
            pidx_q <= pidx_d;
            addr_q <= addr_d;
            dir_q <= dir_d;
            pitch_q <= pitch_d;
            shape_q <= shape_d;
            ovl_q <= ovl_d;
            hsc_q <= hsc_d;
            hi_q <= hi_d;
            first_q <= first_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // registered display-control outputs; blocks two and four tied to graphics
    // ------------------------------------------------------------
    logic blk1_q, blk3_q, l3_q, prio_q, block_q;   // decoded display state
    logic [1:0] comp_q;                             // composition method
    logic [2:0] hsc_o_q;                            // shift output
    logic [15:0] addr_o_q;                          // address output

    // decode overlay settings once per clock
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            blk1_q <= 1'b0;
            blk3_q <= 1'b0;
            l3_q <= 1'b0;
            prio_q <= 1'b0;
            comp_q <= LCO_COMP_OR;
            block_q <= 1'b0;
            hsc_o_q <= 3'h0;
            addr_o_q <= ADDR_RST;
        end else begin
            comp_q <= {ovl_q[OVL_COMP_HI], ovl_q[OVL_COMP_LO]};
            // priority only differs from OR when flashing
            prio_q <= ({ovl_q[OVL_COMP_HI], ovl_q[OVL_COMP_LO]} == LCO_COMP_PRIO);
            blk1_q <= ovl_q[OVL_BLK1];
            blk3_q <= ovl_q[OVL_BLK3];
            // third layer only with graphics first layer
            l3_q <= ovl_q[OVL_LAYERS] & ovl_q[OVL_BLK1];
            block_q <= shape_q;
            hsc_o_q <= hsc_q;
            addr_o_q <= addr_q;
        end
    end

    assign rdata_o = rdata_q;
    assign cursor_block_o = block_q;
    assign compose_sel_o = comp_q;
    assign block1_graphics_o = blk1_q;
    assign block2_graphics_o = 1'b1;
    assign block3_graphics_o = blk3_q;
    assign block4_graphics_o = 1'b1;
    assign third_layer_en_o = l3_q;
    assign flash_priority_o = prio_q;
    assign hscroll_o = hsc_o_q;
    assign cursor_addr_o = addr_o_q;
endmodule

// ---- rtl/lco_pkg.sv ----
package lco_pkg;
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_CSR_FORM = 8'h5d;       // cursor form, shape in p2 bit 7
    localparam logic [7:0] CMD_DIR_BASE = 8'h4c;       // cursor_step_direction_cmd base
    localparam logic [7:0] CMD_OVERLAY = 8'h5b;        // layer_overlay_cmd
    localparam logic [7:0] CMD_HSCROLL = 8'h5a;        // pixel_hscroll_cmd
    localparam logic [7:0] CMD_SET_ADDR = 8'h46;       // set_address_cmd
    localparam logic [7:0] CMD_READ_ADDR = 8'h47;      // read_address_cmd
    localparam logic [7:0] CMD_MEM_WRITE = 8'h42;      // mem_write_cmd
    localparam logic [7:0] CMD_MEM_READ = 8'h43;       // mem_read_cmd
    localparam logic [7:0] CMD_PITCH = 8'h40;          // system set, pitch in p7/p8

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int SHAPE_BIT = 7;                      // cursor_shape_bit in form p2
    localparam int OVL_COMP_LO = 0;                    // compose_sel_lo
    localparam int OVL_COMP_HI = 1;                    // compose_sel_hi
    localparam int OVL_BLK1 = 2;                       // block1_mode_bit
    localparam int OVL_BLK3 = 3;                       // block3_mode_bit
    localparam int OVL_LAYERS = 4;                     // layer_count_bit
    localparam int PITCH_P_LO = 6;                     // param index of pitch low byte
    localparam logic [15:0] PITCH_RST = 16'h0010;      // address pitch after reset
    localparam logic [15:0] ADDR_RST = 16'h0000;
    localparam int MEM_AW = 16;
    localparam int MEM_DEPTH = 1024;                   // words actually stored
    localparam int MEM_IW = 10;

    // composition method codes
    typedef enum logic [1:0] {
        LCO_COMP_OR = 2'b00,
        LCO_COMP_XOR = 2'b01,
        LCO_COMP_AND = 2'b10,
        LCO_COMP_PRIO = 2'b11
    } lco_comp_e;

    // step directions
    typedef enum logic [1:0] {
        LCO_DIR_RIGHT = 2'b00,
        LCO_DIR_LEFT = 2'b01,
        LCO_DIR_UP = 2'b10,
        LCO_DIR_DOWN = 2'b11
    } lco_dir_e;
endpackage

// ---- rtl/lco_mem_if.sv ----
`timescale 1ns/10ps
// display memory port between the interpreter and its memory
interface lco_mem_if;
    logic we;                      // write strobe
    logic [15:0] addr;             // cursor address
    logic [7:0] wdata;             // write byte
    logic [7:0] rdata;             // byte at addr, one cycle later
    modport ctl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface

// ---- rtl/lco_vram.sv ----
`timescale 1ns/10ps
// display memory: only reachable through the interpreter
module lco_vram
    import lco_pkg::*;
(
    input wire logic clk_i,
    lco_mem_if.mem m
);
    // ------------------------------------------------------------
    // storage, low address bits only
    // ------------------------------------------------------------
    logic [7:0] ram [MEM_DEPTH];   // byte array
    logic [7:0] rd_q;              // registered read byte

    // synchronous write and read
    always_ff @(posedge clk_i) begin
        if (m.we) begin
            ram[m.addr[MEM_IW-1:0]] <= m.wdata;
        end
        rd_q <= ram[m.addr[MEM_IW-1:0]];
    end

    assign m.rdata = rd_q;
endmodule

// ---- dv/lco_host_model.sv ----
`timescale 1ns/10ps
// host side of the byte bus: one strobe per cycle, changed after the rising edge
module lco_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic cmd_sel_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        cmd_sel_o = 1'b0;
        wdata_o = 8'h5a;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // one write cycle; command then its parameters in order
    task automatic wr_b(input logic cs, input logic [7:0] b);
        @(posedge clk_i);
        cmd_sel_o <= cs;
        wdata_o <= b;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~b; // released bus shows the inverse of the last byte
    endtask
    task automatic cmd(input logic [7:0] b);
        wr_b(1'b1, b);
    endtask
    task automatic par(input logic [7:0] b);
        wr_b(1'b0, b);
    endtask
    // one read cycle; data taken at the edge closing the answer cycle
    task automatic rd_b(output logic [7:0] d);
        @(posedge clk_i);
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(posedge clk_i);
        d = rdata_i;
    endtask
endmodule

// ---- dv/lco_cmd_monitor.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// port checker for the command interpreter
// ------------------------------------------------------------
module lco_cmd_monitor (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic cmd_sel_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic cursor_block_o,
    input wire logic [1:0] compose_sel_o,
    input wire logic block1_graphics_o,
    input wire logic block2_graphics_o,
    input wire logic block4_graphics_o,
    input wire logic third_layer_en_o,
    input wire logic flash_priority_o,
    input wire logic [2:0] hscroll_o,
    input wire logic [15:0] cursor_addr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // a parameter byte written one or two cycles back
    sequence par_wr_s;
        ($past(wr_i) && !$past(cmd_sel_i)) || ($past(wr_i, 2) && !$past(cmd_sel_i, 2));
    endsequence
    AST_BLK_GFX: assert property (block2_graphics_o && block4_graphics_o)
        else $error("blocks two and four not graphics");
    AST_PRIO: assert property (flash_priority_o == (compose_sel_o == 2'b11))
        else $error("priority flag disagrees with composition");
    AST_THIRD: assert property (third_layer_en_o |-> block1_graphics_o)
        else $error("third layer on with text first layer");
    AST_RD_IDLE: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data outside answer cycle");
    AST_HSCR: assert property ($changed(hscroll_o) |-> par_wr_s)
        else $error("pixel shift changed without parameter");
    AST_COMP: assert property ($changed(compose_sel_o) |-> par_wr_s)
        else $error("composition changed without parameter");
    AST_SHAPE: assert property ($changed(cursor_block_o) |-> par_wr_s)
        else $error("cursor shape changed without parameter");
    AST_ADDR: assert property ($changed(cursor_addr_o) |->
        ($past(wr_i) || $past(rd_i) || $past(wr_i, 2) || $past(rd_i, 2) || $past(rd_i, 3)))
        else $error("cursor address changed without access");
    cover property (third_layer_en_o && compose_sel_o == 2'b01);
    cover property ($rose(rd_i) ##1 rdata_o != 8'h00);
    cover property (hscroll_o == 3'h7);
endmodule
bind lco_cmd lco_cmd_monitor lco_cmd_monitor_i (.clk_i(clk_i), .rstn_i(rstn_i),
    .cmd_sel_i(cmd_sel_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cursor_block_o(cursor_block_o), .compose_sel_o(compose_sel_o),
    .block1_graphics_o(block1_graphics_o), .block2_graphics_o(block2_graphics_o),
    .block4_graphics_o(block4_graphics_o), .third_layer_en_o(third_layer_en_o),
    .flash_priority_o(flash_priority_o), .hscroll_o(hscroll_o),
    .cursor_addr_o(cursor_addr_o));

// ---- dv/tb.sv ----
`timescale 1ns/10ps
// ------------------------------------------------------------
// self-checking bench for the command interpreter
// ------------------------------------------------------------
module tb;
    import lco_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    wire logic cmd_sel_i, wr_i, rd_i, cursor_block_o, block1_graphics_o, block2_graphics_o;
    wire logic block3_graphics_o, block4_graphics_o, third_layer_en_o, flash_priority_o;
    wire logic [7:0] wdata_i, rdata_o;
    wire logic [1:0] compose_sel_o;
    wire logic [2:0] hscroll_o;
    wire logic [15:0] cursor_addr_o;
    logic [7:0] d;
    logic [15:0] base;
    logic [7:0] sys [8] = '{8'h30, 8'h87, 8'h07, 8'h11, 8'h2f, 8'h38, 8'h20, 8'h00};
    logic [15:0] step [4] = '{16'h0001, 16'hffff, 16'hffe0, 16'h0020}; // pitch set to 0x20
    int error_cnt = 0;
    int compares = 0;
    always #20 clk_i = ~clk_i;
    lco_host_model lco_host_model_i (.clk_i(clk_i), .rdata_i(rdata_o), .cmd_sel_o(cmd_sel_i),
        .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
    lco_cmd lco_cmd_i (.clk_i(clk_i), .rstn_i(rstn_i), .cmd_sel_i(cmd_sel_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .cursor_block_o(cursor_block_o), .compose_sel_o(compose_sel_o),
        .block1_graphics_o(block1_graphics_o), .block2_graphics_o(block2_graphics_o),
        .block3_graphics_o(block3_graphics_o), .block4_graphics_o(block4_graphics_o),
        .third_layer_en_o(third_layer_en_o), .flash_priority_o(flash_priority_o),
        .hscroll_o(hscroll_o), .cursor_addr_o(cursor_addr_o));
    // all display settings packed for one compare
    wire [15:0] disp = {4'h0, cursor_block_o, compose_sel_o, block1_graphics_o,
        block2_graphics_o, block3_graphics_o, block4_graphics_o, third_layer_en_o,
        flash_priority_o, hscroll_o};
    function automatic logic [15:0] exp_d(int blk, logic [1:0] c, int g, int th,
                                          logic [2:0] hs);
        return {4'h0, 1'(blk), c, 1'(g), 1'b1, 1'(g), 1'b1, 1'(th), c == 2'b11, hs};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // let the two-cycle settings lag pass, then sample mid-cycle
    task automatic settle();
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        settle();
        chk(disp, exp_d(0, 2'b00, 0, 0, 3'h0));
        chk(cursor_addr_o, ADDR_RST);
        $display("test reset done");
        // cursor shape: underline then block, block kept whatever the layer modes
        lco_host_model_i.cmd(CMD_CSR_FORM);
        lco_host_model_i.par(8'h04);
        lco_host_model_i.par(8'h03);
        settle();
        chk(disp, exp_d(0, 2'b00, 0, 0, 3'h0));
        lco_host_model_i.cmd(CMD_CSR_FORM);
        lco_host_model_i.par(8'h04);
        lco_host_model_i.par(8'h83);
        settle();
        chk(disp, exp_d(1, 2'b00, 0, 0, 3'h0));
        $display("test shape done");
        // every composition with both mode bits graphics and three layers
        for (int c = 0; c < 4; c++) begin
            lco_host_model_i.cmd(CMD_OVERLAY);
            lco_host_model_i.par({6'b000111, c[1:0]});
            settle();
            chk(disp, exp_d(1, c[1:0], 1, 1, 3'h0));
        end
        lco_host_model_i.cmd(CMD_OVERLAY);
        lco_host_model_i.par(8'h13);
        settle();
        chk(disp, exp_d(1, 2'b11, 0, 0, 3'h0));
        lco_host_model_i.cmd(CMD_OVERLAY);
        lco_host_model_i.par(8'h00);
        settle();
        chk(disp, exp_d(1, 2'b00, 0, 0, 3'h0));
        $display("test overlay done");
        // row setup: one spare character, pitch 0x20
        lco_host_model_i.cmd(CMD_PITCH);
        for (int i = 0; i < 8; i++) lco_host_model_i.par(sys[i]);
        for (int i = 7; i >= 0; i--) begin
            lco_host_model_i.cmd(CMD_HSCROLL);
            lco_host_model_i.par(8'(i));
            settle();
            chk(disp, exp_d(1, 2'b00, 0, 0, 3'(i)));
            chk(cursor_addr_o, ADDR_RST);
        end
        $display("test scroll done");
        // unknown command, its data and a stray read leave every setting alone
        lco_host_model_i.cmd(8'h4b);
        lco_host_model_i.par(8'hff);
        lco_host_model_i.rd_b(d);
        chk({8'h00, d}, 16'h0000);
        settle();
        chk(disp, exp_d(1, 2'b00, 0, 0, 3'h0));
        chk(cursor_addr_o, ADDR_RST);
        $display("test refused done");
        lco_host_model_i.cmd(CMD_SET_ADDR);
        lco_host_model_i.par(8'h23);
        lco_host_model_i.par(8'h01);
        settle();
        chk(cursor_addr_o, 16'h0123);
        lco_host_model_i.cmd(CMD_READ_ADDR);
        lco_host_model_i.rd_b(d);
        chk({8'h00, d}, 16'h0023);
        lco_host_model_i.rd_b(d);
        chk({8'h00, d}, 16'h0001);
        $display("test address done");
        // stream two bytes in each direction, then read them back
        for (int k = 0; k < 4; k++) begin
            base = 16'h0200 + step[k] + step[k];
            lco_host_model_i.cmd(CMD_SET_ADDR);
            lco_host_model_i.par(8'h00);
            lco_host_model_i.par(8'h02);
            lco_host_model_i.cmd(CMD_DIR_BASE + 8'(k));
            lco_host_model_i.cmd(CMD_MEM_WRITE);
            lco_host_model_i.par(8'h50 + 8'(k));
            lco_host_model_i.par(8'h60 + 8'(k));
            settle();
            chk(cursor_addr_o, base);
            lco_host_model_i.cmd(CMD_SET_ADDR);
            lco_host_model_i.par(8'h00);
            lco_host_model_i.par(8'h02);
            lco_host_model_i.cmd(CMD_MEM_READ);
            lco_host_model_i.rd_b(d);
            chk({8'h00, d}, 16'h0050 + 16'(k));
            lco_host_model_i.rd_b(d);
            chk({8'h00, d}, 16'h0060 + 16'(k));
            settle();
            chk(cursor_addr_o, base);
        end
        $display("test stream done");
        // reset again mid-run, held long enough for the output stage to settle
        @(posedge clk_i);
        rstn_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        settle();
        chk(disp, exp_d(0, 2'b00, 0, 0, 3'h0));
        chk(cursor_addr_o, ADDR_RST);
        $display("test reset again done");
        complete_run();
    end
endmodule
